// file: src/dcc_pkg.sv
// Shared constants and carrier types for the DAC code calibration datapath
package dcc_pkg;

  // Widths
  localparam int DCC_DW      = 16;  // Storage width of every code word
  localparam int DCC_W16     = 16;  // Code width, 16-bit variant
  localparam int DCC_W14     = 14;  // Code width, 14-bit variant
  localparam int DCC_OFS_W   = 14;  // Group offset code width
  localparam int DCC_CH_W    = 4;   // Channel index width (16 channels)
  localparam int DCC_WORD_W  = 3;   // Word index width inside one channel
  localparam int DCC_SPAN_W  = 18;  // Signed width of the span-relative code
  localparam int DCC_GRP_BIT = 3;   // Channel bit that names the group

  // Power-on defaults, 16-bit variant
  localparam logic [15:0] DCC_IN_DEF16   = 16'h8000;
  localparam logic [15:0] DCC_GAIN_DEF16 = 16'hffff;
  localparam logic [15:0] DCC_OFFS_DEF16 = 16'h8000;
  // Power-on defaults, 14-bit variant
  localparam logic [15:0] DCC_IN_DEF14   = 16'h2000;
  localparam logic [15:0] DCC_GAIN_DEF14 = 16'h3fff;
  localparam logic [15:0] DCC_OFFS_DEF14 = 16'h2000;
  // Group offset default, both variants
  localparam logic [13:0] DCC_GOFS_DEF   = 14'h2000;
  // Left shift of the group offset in the 16-bit variant (times four)
  localparam int          DCC_GOFS_SHL16 = 2;

  // Word index of each register inside a channel's slot
  localparam logic [2:0] DCC_WD_IN_A  = 3'h0;
  localparam logic [2:0] DCC_WD_IN_B  = 3'h1;
  localparam logic [2:0] DCC_WD_GAIN  = 3'h2;
  localparam logic [2:0] DCC_WD_OFFS  = 3'h3;
  localparam logic [2:0] DCC_WD_CAL_A = 3'h4;
  localparam logic [2:0] DCC_WD_CAL_B = 3'h5;

  // Kind of a register load
  typedef enum logic [1:0] {
    DCC_K_INPUT = 2'h0,
    DCC_K_GAIN  = 2'h1,
    DCC_K_OFFS  = 2'h2,
    DCC_K_GOFS  = 2'h3
  } dcc_kind_e;

  // One register load from the host side
  typedef struct packed {
    dcc_kind_e            kind;
    logic [DCC_CH_W-1:0]  channel;
    logic [DCC_DW-1:0]    data;
  } dcc_wr_s;

  // One finished channel computation
  typedef struct packed {
    logic [DCC_CH_W-1:0]   channel;
    logic                  bank;
    logic [DCC_DW-1:0]     code;
    logic [DCC_SPAN_W-1:0] span;
  } dcc_out_s;

endpackage

// file: src/dcc_mem.sv
// Single-port-write, registered-read code memory for all channels
`timescale 1ns/1ps
module dcc_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage array, filled by the init sweep

  // Write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// file: src/dcc_datapath.sv
// Calibration datapath: trim, group offset and output clamp for 16 channels
`timescale 1ns/1ps
import dcc_pkg::*;

//Behaviour
//RULE1 - two 14-bit group offsets shift their groups
//RULE2 - host keeps group offset at most 8192
//RULE3 - clamp low holds outputs grounded, loads still work
//RULE4 - outputs grounded until init and supplies ready
//RULE5 - 16-bit code is X(M+1)/2^16+C-2^15
//RULE6 - 16-bit defaults 32768, 2^16-1, 2^15
//RULE7 - 16-bit group offset scaled by four
//RULE8 - host keeps 16-bit code within 0..65535
//RULE9 - group offsets default to 8192
//RULE10 - 14-bit formula, defaults, unscaled group offset
//RULE11 - host keeps 14-bit code within 0..16383
//RULE12 - host trims zero-scale via offset trim
//RULE13 - host trims span via gain trim
//RULE14 - host measures both errors before trimming
//RULE15 - input or selected-bank trim load recomputes
//RULE16 - one shared multiplier, channels one by one
//RULE17 - format select converts input, offset, group only
//RULE18 - divide by dropping low product bits
module dcc_datapath #(
  parameter bit VARIANT16 = 1'b1
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              output_clamp_n,
  input  wire logic              supply_valid,
  input  wire logic              code_format_select,
  input  wire logic              bank_select,
  input  wire logic              wr_valid,
  input  wire dcc_pkg::dcc_wr_s  wr,
  output logic                   wr_ready,
  output logic                   busy,
  output logic                   init_done,
  output logic                   tie_to_ground,
  output logic [13:0]            group0_offset_code,
  output logic [13:0]            group1_offset_code,
  output logic                   out_valid,
  output dcc_pkg::dcc_out_s      out
);
  import dcc_pkg::*;

  localparam int W  = VARIANT16 ? DCC_W16 : DCC_W14;  // Active code width
  localparam int AW = DCC_CH_W + DCC_WORD_W;          // Memory address width
  localparam logic [DCC_DW-1:0] IN_DEF   = VARIANT16 ? DCC_IN_DEF16 : DCC_IN_DEF14;
  localparam logic [DCC_DW-1:0] GAIN_DEF = VARIANT16 ? DCC_GAIN_DEF16 : DCC_GAIN_DEF14;
  localparam logic [DCC_DW-1:0] OFFS_DEF = VARIANT16 ? DCC_OFFS_DEF16 : DCC_OFFS_DEF14;
  localparam logic [W+1:0]      HALF     = (W+2)'(1) << (W - 1);  // Mid-scale subtrahend

  // Sequencer states, Gray coded along init, idle and the compute walk
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_IDLE = 3'b001,
    ST_RX   = 3'b011,
    ST_RM   = 3'b010,
    ST_RC   = 3'b110,
    ST_MUL  = 3'b111,
    ST_WR   = 3'b101
  } dcc_state_e;

  dcc_state_e          state_q, state_d;  // Sequencer state
  logic [AW-1:0]       init_addr_q;       // Init sweep address
  logic [DCC_CH_W-1:0] ch_q;              // Channel being computed
  logic                bank_q;            // Bank being computed
  logic [W-1:0]        x_q, m_q;          // Input and gain operands fetched from memory
  logic [DCC_DW-1:0]   cal_q;             // Calibrated code of the walk
  logic [13:0]         gofs_q [2];        // Group offset codes
  logic                init_done_q;       // Init sweep finished
  logic                tie_q;             // Outputs held at signal ground
  logic                out_valid_q;       // Result strobe
  dcc_out_s            out_q;             // Result word

  // Memory port wires
  logic                mem_we;
  logic [AW-1:0]       mem_waddr, mem_raddr;
  logic [DCC_DW-1:0]   mem_wdata, mem_rdata;

  // Handshake and load decode
  wire wr_fire  = wr_valid && wr_ready;
  wire is_gain  = wr.kind == DCC_K_GAIN;
  wire is_gofs  = wr.kind == DCC_K_GOFS;
  wire grp_sel  = wr.channel[DCC_GRP_BIT];
  wire [DCC_WORD_W-1:0] wr_word = (wr.kind == DCC_K_INPUT) ? (bank_select ? DCC_WD_IN_B : DCC_WD_IN_A) :
                                  is_gain ? DCC_WD_GAIN : DCC_WD_OFFS;

  // Twos complement to offset binary: flip the sign bit, never for gain
  wire [DCC_DW-1:0] msb_code = DCC_DW'(1) << (W - 1);
  wire [DCC_DW-1:0] msb_gofs = DCC_DW'(1) << (DCC_OFS_W - 1);
  wire [DCC_DW-1:0] flip     = (!code_format_select || is_gain) ? '0 : (is_gofs ? msb_gofs : msb_code); // RULE17
  wire [DCC_DW-1:0] wr_conv  = wr.data ^ flip; // RULE17

  // Default word for the init sweep, chosen by word index
  wire [DCC_WORD_W-1:0] init_word = init_addr_q[DCC_WORD_W-1:0];
  wire [DCC_DW-1:0]     init_data = (init_word == DCC_WD_GAIN) ? GAIN_DEF :
                                    (init_word == DCC_WD_OFFS) ? OFFS_DEF :
                                    (init_word <= DCC_WD_CAL_B) ? IN_DEF : '0; // RULE6 RULE10
  wire                  init_last = &init_addr_q;

  // The offset trim word arrives on the read port in ST_MUL and is used straight from there
  wire [W-1:0]   c_live   = mem_rdata[W-1:0];

  // Shared multiplier and adder; the quotient drops the low bits
  wire [2*W:0]   prod     = (2*W+1)'(x_q) * (2*W+1)'({1'b0, m_q} + (W+1)'(1)); // RULE5 RULE10 RULE16
  wire [W:0]     quot     = prod[2*W:W]; // RULE18
  wire [W+1:0]   cal_full = (W+2)'(quot) + (W+2)'(c_live) - HALF; // RULE5 RULE10

  // Group offset aligned to the code range of the variant
  wire [13:0]         gofs_sel = gofs_q[ch_q[DCC_GRP_BIT]];
  wire [DCC_DW-1:0]   gofs_al  = VARIANT16 ? (DCC_DW'(gofs_sel) << DCC_GOFS_SHL16) : DCC_DW'(gofs_sel); // RULE7 RULE10
  wire [DCC_SPAN_W-1:0] span   = DCC_SPAN_W'(cal_q) - DCC_SPAN_W'(gofs_al); // RULE1

  // Memory address selection per state
  wire [DCC_WORD_W-1:0] rd_word = (state_q == ST_RX) ? (bank_q ? DCC_WD_IN_B : DCC_WD_IN_A) :
                                  (state_q == ST_RM) ? DCC_WD_GAIN : DCC_WD_OFFS;
  assign mem_raddr = {ch_q, rd_word};
  assign mem_we    = (state_q == ST_INIT) || (wr_fire && !is_gofs) || (state_q == ST_WR);
  assign mem_waddr = (state_q == ST_INIT) ? init_addr_q :
                     (state_q == ST_WR) ? {ch_q, bank_q ? DCC_WD_CAL_B : DCC_WD_CAL_A} :
                     {wr.channel, wr_word};
  assign mem_wdata = (state_q == ST_INIT) ? init_data : (state_q == ST_WR) ? cal_q : wr_conv;

  // Next state: one channel walks through fetch, multiply and write back
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_INIT: state_d = init_last ? ST_IDLE : ST_INIT;
      ST_IDLE: state_d = (wr_fire && !is_gofs) ? ST_RX : ST_IDLE; // RULE15
      ST_RX:   state_d = ST_RM;
      ST_RM:   state_d = ST_RC;
      ST_RC:   state_d = ST_MUL;
      ST_MUL:  state_d = ST_WR;
      ST_WR:   state_d = ST_IDLE;
      default: state_d = ST_INIT;
    endcase
  end

  // State and sweep counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_INIT;
      init_addr_q <= '0;
      init_done_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      init_addr_q <= (state_q == ST_INIT) ? init_addr_q + AW'(1) : init_addr_q;
      init_done_q <= init_done_q || (state_q == ST_INIT && init_last);
    end
  end

  // Latch channel and bank; the trim bank follows bank select at the load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ch_q   <= '0;
      bank_q <= 1'b0;
    end else if (wr_fire && !is_gofs) begin
      ch_q   <= wr.channel; // RULE15
      bank_q <= bank_select; // RULE15
    end
  end

  // Operand capture: read data trails its address by one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_q   <= '0;
      m_q   <= '0;
      cal_q <= '0;
    end else begin
      if (state_q == ST_RM)  x_q <= mem_rdata[W-1:0];
      if (state_q == ST_RC)  m_q <= mem_rdata[W-1:0];
      if (state_q == ST_MUL) cal_q <= DCC_DW'(cal_full[W-1:0]);
    end
  end

  // Group offset registers, loaded with their default at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gofs_q[0] <= DCC_GOFS_DEF; // RULE9
      gofs_q[1] <= DCC_GOFS_DEF; // RULE9
    end else if (wr_fire && is_gofs) begin
      gofs_q[grp_sel] <= wr_conv[DCC_OFS_W-1:0]; // RULE1
    end
  end

  // Output ground clamp: clamp pin, init sweep and supplies must all agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tie_q <= 1'b1;
    end else begin
      tie_q <= !(output_clamp_n && init_done_q && supply_valid); // RULE3 RULE4
    end
  end

  // Result strobe and word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_q       <= '0;
    end else begin
      out_valid_q <= (state_q == ST_WR);
      if (state_q == ST_WR) out_q <= '{channel: ch_q, bank: bank_q, code: cal_q, span: span};
    end
  end

  // Memory instance
  dcc_mem #(
    .WIDTH (DCC_DW),
    .DEPTH (1 << AW),
    .AW    (AW)
  ) u_mem (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // Port drives
  assign wr_ready           = (state_q == ST_IDLE); // RULE16
  assign busy               = (state_q != ST_IDLE);
  assign init_done          = init_done_q;
  assign tie_to_ground      = tie_q;
  assign group0_offset_code = gofs_q[0];
  assign group1_offset_code = gofs_q[1];
  assign out_valid          = out_valid_q;
  assign out                = out_q;

  // Reference value of the trim formula, computed with wide integers
  longint exp_cal;
  assign exp_cal = (longint'(x_q) * (longint'(m_q) + 1)) / (longint'(1) << W) + longint'(c_live)
                   - (longint'(1) << (W - 1));

  // Checks
  a_clamp_ground: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    !output_clamp_n |=> tie_to_ground) else $error("clamp low but output not grounded");
  a_init_ground: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    (!init_done || !supply_valid) |=> tie_to_ground) else $error("output released before init or supply");
  a_release_out: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    (output_clamp_n && init_done && supply_valid) [*2] |-> !tie_to_ground) else $error("output not released");
  a_cal_formula: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    state_q == ST_MUL |=> cal_q[W-1:0] == W'($past(exp_cal))) else $error("calibrated code wrong");
  a_span_offset: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    out_valid |-> out.span == DCC_SPAN_W'(out.code) - DCC_SPAN_W'(VARIANT16 ?
      {gofs_q[out.channel[DCC_GRP_BIT]], 2'b00} : {2'b00, gofs_q[out.channel[DCC_GRP_BIT]]}))
    else $error("group offset not applied");
  a_group_default: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    !init_done |-> group0_offset_code == DCC_GOFS_DEF && group1_offset_code == DCC_GOFS_DEF)
    else $error("group offset default wrong");
  a_recalc_time: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    wr_fire && !is_gofs |-> ##6 out_valid && out.channel == $past(wr.channel, 6)) else $error("no recompute");
  a_single_unit: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
    wr_fire && !is_gofs |=> !wr_ready [*5] ##1 wr_ready) else $error("load taken while busy");
  a_gain_raw: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    wr_fire && is_gain |-> mem_wdata == wr.data) else $error("gain trim converted");
  a_init_default: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    state_q == ST_INIT && init_word == DCC_WD_GAIN |-> mem_wdata == GAIN_DEF) else $error("gain default wrong");

  c_result: cover property (@(posedge clk) disable iff (!rst_n) out_valid);
  c_release: cover property (@(posedge clk) disable iff (!rst_n) $fell(tie_to_ground));
  c_gofs_load: cover property (@(posedge clk) disable iff (!rst_n) wr_fire && is_gofs && code_format_select);

endmodule

// file: test/dcc_host.sv
// Host-side model that loads codes into the calibration datapath
`timescale 1ns/1ps
module dcc_host (
  input  wire logic       clk,
  input  wire logic       wr_ready,
  output logic            wr_valid,
  output dcc_pkg::dcc_wr_s wr,
  output logic            code_format_select,
  output logic            bank_select
);
  import dcc_pkg::*;

  // Idle bus at time zero
  initial begin
    wr_valid           = 1'b0;
    wr                 = '0;
    code_format_select = 1'b0;
    bank_select        = 1'b0;
  end

  // One load: raise at a falling edge, hold until the taking edge, then release
  task automatic load(dcc_kind_e k, logic [3:0] ch, logic [15:0] d, logic fmt, logic bk);
    logic [15:0] dv;
    dv = d;
    // Never push a group offset above mid-scale
    if (k == DCC_K_GOFS && (dv[13:0] ^ {fmt, 13'h0}) > 14'h2000) begin
      dv = {2'h0, 14'h2000 ^ {fmt, 13'h0}};
    end
    @(negedge clk);
    wr                 = '{kind: k, channel: ch, data: dv};
    code_format_select = fmt;
    bank_select        = bk;
    wr_valid           = 1'b1;
    // Refused loads are held for up to 64 cycles
    for (int i = 0; i < 64 && wr_ready !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    // Released data lines must not keep the old value
    wr_valid = 1'b0;
    wr.data  = ~dv;
  endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the calibration datapath, 16-bit variant
`timescale 1ns/1ps
module testbench;
  import dcc_pkg::*;

  logic                clk;                 // 100 MHz clock
  logic                rst_n;               // Reset, active low
  logic                output_clamp_n;      // Clamp input
  logic                supply_valid;        // Supplies good
  logic                code_format_select;  // Driven by host model
  logic                bank_select;         // Driven by host model
  logic                wr_valid;            // Load request
  dcc_wr_s             wr;                  // Load word
  logic                wr_ready;            // Load accepted
  logic                busy;                // Sequencer busy
  logic                init_done;           // Init sweep finished
  logic                tie_to_ground;       // Outputs grounded
  logic [13:0]         group0_offset_code;  // Group 0 offset
  logic [13:0]         group1_offset_code;  // Group 1 offset
  logic                out_valid;           // Result strobe
  dcc_out_s            out;                 // Result
  logic [15:0]         in_a[16];            // Model of input A
  logic [15:0]         in_b[16];            // Model of input B
  logic [15:0]         gn[16];              // Model of gain trim
  logic [15:0]         of[16];              // Model of offset trim
  logic [13:0]         go[2];               // Model of group offsets
  dcc_out_s            exp_q[$];            // Expected results
  logic [31:0]         rnd;                 // Random state
  int                  errors;              // Mismatch count
  int                  n_checks;            // Comparison count

  dcc_datapath #(.VARIANT16(1'b1)) u_dut (
    .clk(clk), .rst_n(rst_n), .output_clamp_n(output_clamp_n), .supply_valid(supply_valid),
    .code_format_select(code_format_select), .bank_select(bank_select), .wr_valid(wr_valid),
    .wr(wr), .wr_ready(wr_ready), .busy(busy), .init_done(init_done), .tie_to_ground(tie_to_ground),
    .group0_offset_code(group0_offset_code), .group1_offset_code(group1_offset_code),
    .out_valid(out_valid), .out(out)
  );

  dcc_host u_host (
    .clk(clk), .wr_ready(wr_ready), .wr_valid(wr_valid), .wr(wr),
    .code_format_select(code_format_select), .bank_select(bank_select)
  );

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic summarize();
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(string what, logic [38:0] seen, logic [38:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Random step
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected result of one channel and bank
  function automatic dcc_out_s exp_out(logic [3:0] ch, logic bk);
    logic [32:0] p;
    dcc_out_s    e;
    p         = {17'h0, bk ? in_b[ch] : in_a[ch]} * ({17'h0, gn[ch]} + 33'h1);
    e.channel = ch;
    e.bank    = bk;
    e.code    = p[31:16] + of[ch] - 16'h8000;
    e.span    = {2'h0, e.code} - {2'h0, go[ch[DCC_GRP_BIT]], 2'h0};
    return e;
  endfunction

  // Update the model, note the expected result, then load
  task automatic ld(dcc_kind_e k, logic [3:0] ch, logic [15:0] d, logic fmt, logic bk);
    logic [15:0] dv;
    dv = d;
    if (fmt && (k == DCC_K_INPUT || k == DCC_K_OFFS)) dv[15] = ~dv[15];
    if (fmt && k == DCC_K_GOFS) dv[13] = ~dv[13];
    case (k)
      DCC_K_INPUT: begin
        if (bk) in_b[ch] = dv;
        else in_a[ch] = dv;
      end
      DCC_K_GAIN: gn[ch] = dv;
      DCC_K_OFFS: of[ch] = dv;
      default: go[ch[DCC_GRP_BIT]] = dv[13:0];
    endcase
    if (k != DCC_K_GOFS) exp_q.push_back(exp_out(ch, bk));
    u_host.load(k, ch, d, fmt, bk);
    if (k == DCC_K_GOFS) begin
      chk("group0 offset", 39'(group0_offset_code), 39'(go[0]));
      chk("group1 offset", 39'(group1_offset_code), 39'(go[1]));
    end
  endtask

  // Result watcher: oldest note against each result
  always @(negedge clk) begin
    if (out_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected result", 39'(out), 39'h0);
      else chk("result", out, exp_q.pop_front());
    end
  end

  // Watchdog
  initial begin
    #200000;
    errors++;
    summarize();
  end

  // Main sequence
  initial begin
    dcc_kind_e   k;
    logic [15:0] d;
    errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    output_clamp_n = 1'b1;
    supply_valid = 1'b1;
    rnd = 32'h7947;
    for (int i = 0; i < 16; i++) begin
      in_a[i] = DCC_IN_DEF16;
      in_b[i] = DCC_IN_DEF16;
      gn[i]   = DCC_GAIN_DEF16;
      of[i]   = DCC_OFFS_DEF16;
    end
    go[0] = DCC_GOFS_DEF;
    go[1] = DCC_GOFS_DEF;
    repeat (16) @(negedge clk);
    chk("tie in reset", 39'(tie_to_ground), 39'h1);
    chk("busy in reset", 39'(busy), 39'h1);
    chk("group0 default", 39'(group0_offset_code), 39'(DCC_GOFS_DEF));
    chk("group1 default", 39'(group1_offset_code), 39'(DCC_GOFS_DEF));
    rst_n = 1'b1;
    for (int i = 0; i < 300 && init_done !== 1'b1; i++) @(negedge clk);
    chk("tie at init end", 39'(tie_to_ground), 39'h1);
    chk("init done", 39'(init_done), 39'h1);
    chk("ready after init", 39'(wr_ready), 39'h1);
    chk("busy after init", 39'(busy), 39'h0);
    @(negedge clk);
    chk("tie released", 39'(tie_to_ground), 39'h0);
    // Defaults on both banks, then group offset on group 1
    ld(DCC_K_INPUT, 4'h0, 16'h1234, 1'b0, 1'b0);
    ld(DCC_K_INPUT, 4'h9, 16'hbeef, 1'b0, 1'b1);
    ld(DCC_K_GOFS, 4'h8, 16'h1000, 1'b0, 1'b0);
    ld(DCC_K_INPUT, 4'hc, 16'h4321, 1'b0, 1'b0);
    // Twos complement for every kind
    ld(DCC_K_INPUT, 4'h5, 16'h9000, 1'b1, 1'b0);
    ld(DCC_K_GAIN, 4'h5, 16'hc000, 1'b1, 1'b0);
    ld(DCC_K_OFFS, 4'h5, 16'h0010, 1'b1, 1'b0);
    ld(DCC_K_GOFS, 4'h5, 16'h0000, 1'b1, 1'b0);
    // Trim written only once both errors are known
    ld(DCC_K_OFFS, 4'h2, DCC_OFFS_DEF16 + 16'd98, 1'b0, 1'b0);
    ld(DCC_K_GAIN, 4'h2, DCC_GAIN_DEF16 - 16'd164, 1'b0, 1'b0);
    // Clamp low grounds outputs but loads still work
    output_clamp_n = 1'b0;
    @(negedge clk);
    chk("tie clamped", 39'(tie_to_ground), 39'h1);
    ld(DCC_K_INPUT, 4'h3, 16'h2222, 1'b0, 1'b1);
    output_clamp_n = 1'b1;
    @(negedge clk);
    chk("tie unclamped", 39'(tie_to_ground), 39'h0);
    supply_valid = 1'b0;
    @(negedge clk);
    chk("tie no supply", 39'(tie_to_ground), 39'h1);
    supply_valid = 1'b1;
    // Random loads kept inside the code range
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      k = dcc_kind_e'(rnd[1:0] % 2'h3);
      if (k == DCC_K_INPUT) d = 16'h1000 + rnd[31:16] % 16'hd000;
      else if (k == DCC_K_GAIN) d = {1'b1, rnd[30:16]};
      else d = 16'h7c00 + {5'h0, rnd[26:16]};
      ld(k, rnd[7:4], d, 1'b0, rnd[8]);
    end
    for (int i = 0; i < 50 && exp_q.size() != 0; i++) @(negedge clk);
    chk("pending results", 39'(exp_q.size()), 39'h0);
    summarize();
  end
endmodule
